// ==== octdac_params.svh ====
// constants for the octal converter serial command decoder
`ifndef OCTDAC_PARAMS_SVH
`define OCTDAC_PARAMS_SVH

// =====================================================================
// frame layout
// =====================================================================
`define OCTDAC_FRAME_BITS     24
`define OCTDAC_FRAME_TOP      23
`define OCTDAC_CMD_MSB        23
`define OCTDAC_CMD_LSB        20
`define OCTDAC_ADDR_MSB       19
`define OCTDAC_ADDR_LSB       16
`define OCTDAC_DATA_MSB       15
`define OCTDAC_DATA_BITS      16
`define OCTDAC_CHANNELS       8
`define OCTDAC_MASK_MSB       7

// =====================================================================
// field positions inside setup words
// =====================================================================
`define OCTDAC_REF_OFF_BIT    0
`define OCTDAC_GAIN_BIT       2
`define OCTDAC_CHAIN_BIT      0

// =====================================================================
// power-on values
// =====================================================================
`define OCTDAC_RST_CODE       16'h0000
`define OCTDAC_RST_PD         16'h0000
`define OCTDAC_RST_MASK       8'h00
`define OCTDAC_RST_REF_ON     1'b1
`define OCTDAC_RST_GAIN       1'b0
`define OCTDAC_RST_CHAIN      1'b0
`define OCTDAC_RB_FILL        8'h00

`endif

// ==== octdac_pkg.sv ====
// shared types of the octal converter serial command decoder
package octdac_pkg;

	// =================================================================
	// command codes carried in the top nibble of a frame
	// =================================================================
	typedef enum logic [3:0] {
		OCTDAC_CMD_NOP       = 4'h0,
		OCTDAC_CMD_WR_IN     = 4'h1,
		OCTDAC_CMD_UPDATE    = 4'h2,
		OCTDAC_CMD_WR_UPD    = 4'h3,
		OCTDAC_CMD_POWER     = 4'h4,
		OCTDAC_CMD_LOAD_MASK = 4'h5,
		OCTDAC_CMD_SW_RESET  = 4'h6,
		OCTDAC_CMD_REF_GAIN  = 4'h7,
		OCTDAC_CMD_CHAIN     = 4'h8,
		OCTDAC_CMD_READBACK  = 4'h9,
		OCTDAC_CMD_WR_ALL    = 4'hA,
		OCTDAC_CMD_WRUPD_ALL = 4'hB,
		OCTDAC_CMD_FILLER    = 4'hF
	} octdac_cmd_type;

	// =================================================================
	// serial front end states, gray along idle -> shift -> exec
	// =================================================================
	typedef enum logic [1:0] {
		OCTDAC_FE_IDLE  = 2'b00,
		OCTDAC_FE_SHIFT = 2'b01,
		OCTDAC_FE_EXEC  = 2'b11
	} octdac_fe_state_type;

endpackage

// ==== octdac_link_if.sv ====
// carrier between the serial front end and the command core
`timescale 1ns/10ps

interface octdac_link_if;
	logic        frame_strobe;   // one cycle: frame closed
	logic [23:0] frame_word;     // shift register at frame close
	logic        frame_idle;     // frame select seen high
	logic        preload_strobe; // one cycle: load readback word
	logic [23:0] preload_word;   // word to shift out next frame

	modport front (
		output frame_strobe,
		output frame_word,
		output frame_idle,
		input  preload_strobe,
		input  preload_word
	);

	modport core (
		input  frame_strobe,
		input  frame_word,
		input  frame_idle,
		output preload_strobe,
		output preload_word
	);
endinterface

// ==== octdac_serial_front.sv ====
// serial front end: pin synchronisers, shift register, serial output
`timescale 1ns/10ps
`include "octdac_params.svh"

module octdac_serial_front
	import octdac_pkg::*;
(
	input  wire logic      ref_clk_i,
	input  wire logic      rst_i,
	input  wire logic      sclk_i,
	input  wire logic      frame_sel_n_i,
	input  wire logic      serial_data_in_i,
	output logic           serial_data_out_o,
	octdac_link_if.front   link
);

	// =================================================================
	// synchronisers
	// =================================================================
	logic                  sclk_s1_reg;  // first stage
	logic                  sclk_s2_reg;  // second stage
	logic                  sclk_s3_reg;  // edge history
	logic                  sel_s1_reg;   // first stage
	logic                  sel_s2_reg;   // second stage
	logic                  sdi_s1_reg;   // first stage
	logic                  sdi_s2_reg;   // second stage
	logic [23:0]           shift_reg;    // input shift register
	logic                  sdo_reg;      // serial output bit
	logic                  strobe_reg;   // frame close pulse
	octdac_fe_state_type   state_reg;    // front end state
	octdac_fe_state_type   state_next;   // next state
	wire                   sclk_fall;    // falling serial clock
	wire                   sclk_rise;    // rising serial clock

	// two flops on every pin before any logic reads it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			{sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h7;
			{sel_s1_reg, sel_s2_reg} <= 2'h3;
			{sdi_s1_reg, sdi_s2_reg} <= 2'h0;
		end else begin
			{sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {sclk_i, sclk_s1_reg, sclk_s2_reg};
			{sel_s1_reg, sel_s2_reg} <= {frame_sel_n_i, sel_s1_reg};
			{sdi_s1_reg, sdi_s2_reg} <= {serial_data_in_i, sdi_s1_reg};
		end
	end

	assign sclk_fall = sclk_s3_reg & ~sclk_s2_reg;
	assign sclk_rise = ~sclk_s3_reg & sclk_s2_reg;

	// =================================================================
	// frame state machine
	// =================================================================
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			OCTDAC_FE_IDLE: begin
				if (!sel_s2_reg) state_next = OCTDAC_FE_SHIFT;
			end
			OCTDAC_FE_SHIFT: begin
				// a frame closes on select rising, short or not
				if (sel_s2_reg) state_next = OCTDAC_FE_EXEC;
			end
			default: begin
				state_next = OCTDAC_FE_IDLE;
			end
		endcase
	end

	// state register and frame close pulse
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg  <= OCTDAC_FE_IDLE;
			strobe_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			strobe_reg <= (state_reg == OCTDAC_FE_SHIFT) && sel_s2_reg;
		end
	end

	// msb first shift on falling edges, output moves on rising edges
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			shift_reg <= 24'h000000;
			sdo_reg   <= 1'b0;
		end else if (link.preload_strobe) begin
			shift_reg <= link.preload_word;
			sdo_reg   <= link.preload_word[`OCTDAC_FRAME_TOP];
		end else if (state_reg == OCTDAC_FE_SHIFT && !sel_s2_reg) begin
			if (sclk_fall) begin
				shift_reg <= {shift_reg[`OCTDAC_FRAME_TOP-1:0], sdi_s2_reg};
			end
			if (sclk_rise) begin
				sdo_reg <= shift_reg[`OCTDAC_FRAME_TOP];
			end
		end
	end

	assign link.frame_strobe = strobe_reg;
	assign link.frame_word   = shift_reg;
	assign link.frame_idle   = sel_s2_reg;
	assign serial_data_out_o = sdo_reg;

endmodule

// ==== octdac_command_core.sv ====
// command decoder and register banks of the octal converter
`timescale 1ns/10ps
`include "octdac_params.svh"

module octdac_command_core
	import octdac_pkg::*;
#(
	parameter int CODE_WIDTH = 16
) (
	input  wire logic                                ref_clk_i,
	input  wire logic                                rst_i,
	input  wire logic                                sclk_i,
	input  wire logic                                frame_sel_n_i,
	input  wire logic                                serial_data_in_i,
	input  wire logic                                load_outputs_n_i,
	input  wire logic                                chip_scale_i,
	output logic                                     serial_data_out_o,
	output logic                                     serial_data_out_oe_o,
	output logic [`OCTDAC_CHANNELS-1:0][CODE_WIDTH-1:0] input_code_o,
	output logic [`OCTDAC_CHANNELS-1:0][CODE_WIDTH-1:0] output_code_o,
	output logic [15:0]                              powerdown_mode_o,
	output logic [7:0]                               load_mask_o,
	output logic                                     ref_enable_o,
	output logic                                     gain_double_o,
	output logic                                     chain_enable_o
);

	// =================================================================
	// elaboration check
	// =================================================================
	generate
		if (CODE_WIDTH != 12 && CODE_WIDTH != 16) begin : g_bad_width
			$error("code width must be 12 or 16");
		end
	endgenerate

	localparam int CH = `OCTDAC_CHANNELS;

	// =================================================================
	// functions
	// =================================================================
	// address to one-hot channel select, empty above channel 7
	function automatic logic [CH-1:0] octdac_onehot(input logic [3:0] addr);
		logic [CH-1:0] sel;
		sel = '0;
		if (addr < 4'(CH)) begin
			sel[addr[2:0]] = 1'b1;
		end
		return sel;
	endfunction

	// left-align a channel code into the 16-bit data word
	function automatic logic [15:0] octdac_align(input logic [CODE_WIDTH-1:0] code);
		logic [15:0] word;
		word = 16'h0000;
		word[`OCTDAC_DATA_MSB -: CODE_WIDTH] = code;
		return word;
	endfunction

	// =================================================================
	// front end
	// =================================================================
	octdac_link_if link ();

	octdac_serial_front u_front (
		.ref_clk_i         (ref_clk_i),
		.rst_i             (rst_i),
		.sclk_i            (sclk_i),
		.frame_sel_n_i     (frame_sel_n_i),
		.serial_data_in_i  (serial_data_in_i),
		.serial_data_out_o (serial_data_out_o),
		.link              (link.front)
	);

	// =================================================================
	// pin synchronisers for load line and package strap
	// =================================================================
	logic ld_s1_reg;  // first stage
	logic ld_s2_reg;  // second stage
	logic ld_s3_reg;  // edge history
	logic cs_s1_reg;  // first stage
	logic cs_s2_reg;  // second stage

	// two flops before any logic reads the pins
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			{ld_s1_reg, ld_s2_reg, ld_s3_reg} <= 3'h7;
			{cs_s1_reg, cs_s2_reg} <= 2'h0;
		end else begin
			{ld_s1_reg, ld_s2_reg, ld_s3_reg} <= {load_outputs_n_i, ld_s1_reg, ld_s2_reg};
			{cs_s1_reg, cs_s2_reg} <= {chip_scale_i, cs_s1_reg};
		end
	end

	// =================================================================
	// frame decode
	// =================================================================
	wire                  exec;        // frame closed this cycle
	wire [3:0]            cmd_raw;     // command nibble
	wire [3:0]            addr;        // channel address nibble
	wire [15:0]           data;        // data word
	wire [CODE_WIDTH-1:0] code;        // channel code from data
	wire [CH-1:0]         addr_sel;    // addressed channel
	wire                  load_low;    // load line held low
	wire                  load_fall;   // load line falling edge
	octdac_cmd_type       cmd;         // typed command

	assign exec      = link.frame_strobe;
	assign cmd_raw   = link.frame_word[`OCTDAC_CMD_MSB:`OCTDAC_CMD_LSB];
	assign addr      = link.frame_word[`OCTDAC_ADDR_MSB:`OCTDAC_ADDR_LSB];
	assign data      = link.frame_word[`OCTDAC_DATA_MSB:0];
	assign code      = data[`OCTDAC_DATA_MSB -: CODE_WIDTH];
	assign addr_sel  = octdac_onehot(addr);
	assign load_low  = ~ld_s2_reg;
	assign load_fall = ld_s3_reg & ~ld_s2_reg;
	assign cmd       = octdac_cmd_type'(cmd_raw);

	// command hits, all gated by frame close; nop, filler, reserved hit nothing
	wire hit_wr_in  = exec && cmd == OCTDAC_CMD_WR_IN;
	wire hit_update = exec && cmd == OCTDAC_CMD_UPDATE;
	wire hit_wr_upd = exec && cmd == OCTDAC_CMD_WR_UPD;
	wire hit_power  = exec && cmd == OCTDAC_CMD_POWER;
	wire hit_mask   = exec && cmd == OCTDAC_CMD_LOAD_MASK;
	wire hit_reset  = exec && cmd == OCTDAC_CMD_SW_RESET;
	wire hit_ref    = exec && cmd == OCTDAC_CMD_REF_GAIN;
	wire hit_chain  = exec && cmd == OCTDAC_CMD_CHAIN;
	wire hit_rb     = exec && cmd == OCTDAC_CMD_READBACK;
	wire hit_wr_all = exec && cmd == OCTDAC_CMD_WR_ALL;
	wire hit_wu_all = exec && cmd == OCTDAC_CMD_WRUPD_ALL;

	// =================================================================
	// register banks
	// =================================================================
	logic [CH-1:0][CODE_WIDTH-1:0] in_reg;       // input registers
	logic [CH-1:0][CODE_WIDTH-1:0] in_next;      // next input registers
	logic [CH-1:0][CODE_WIDTH-1:0] out_reg;      // output registers
	logic [CH-1:0][CODE_WIDTH-1:0] out_next;     // next output registers
	logic [15:0]                   pd_reg;       // power-down modes
	logic [7:0]                    mask_reg;     // hardware load mask
	logic                          ref_on_reg;   // reference enabled
	logic                          gain_reg;     // output gain of two
	logic                          chain_reg;    // chained operation
	logic                          rb_active_reg;// readback shifting out
	logic                          oe_reg;       // serial output enable
	logic                          pre_reg;      // preload pulse
	logic [23:0]                   pre_word_reg; // preload word
	wire  [CH-1:0]                 wr_in;        // input register write
	wire  [CH-1:0]                 pass;         // write also to output
	wire  [CH-1:0]                 copy;         // input to output copy

	// per-channel write, pass-through and copy terms
	genvar k;
	generate
		for (k = 0; k < CH; k++) begin : g_ch
			assign wr_in[k] = ((hit_wr_in | hit_wr_upd) & addr_sel[k])
				| hit_wr_all | hit_wu_all;
			assign pass[k] = (((hit_wr_in & addr_sel[k]) | hit_wr_all)
				& ((load_low & ~mask_reg[k]) | cs_s2_reg))
				| (hit_wr_upd & addr_sel[k]) | hit_wu_all;
			assign copy[k] = (hit_update & data[k])
				| (load_fall & link.frame_idle & ~mask_reg[k]);
		end
	endgenerate

	// next values of both banks
	always_comb begin
		in_next  = in_reg;
		out_next = out_reg;
		for (int i = 0; i < CH; i++) begin
			if (wr_in[i]) begin
				in_next[i] = code;
			end
			if (pass[i]) begin
				out_next[i] = code;
			end else if (copy[i]) begin
				out_next[i] = in_reg[i];
			end
		end
	end

	// channel banks, cleared by reset or software reset
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || hit_reset) begin
			in_reg  <= {CH{CODE_WIDTH'(`OCTDAC_RST_CODE)}};
			out_reg <= {CH{CODE_WIDTH'(`OCTDAC_RST_CODE)}};
		end else begin
			in_reg  <= in_next;
			out_reg <= out_next;
		end
	end

	// mode and setup registers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || hit_reset) begin
			pd_reg     <= `OCTDAC_RST_PD;
			mask_reg   <= `OCTDAC_RST_MASK;
			ref_on_reg <= `OCTDAC_RST_REF_ON;
			gain_reg   <= `OCTDAC_RST_GAIN;
			chain_reg  <= `OCTDAC_RST_CHAIN;
		end else begin
			if (hit_power) pd_reg <= data;
			if (hit_mask) mask_reg <= data[`OCTDAC_MASK_MSB:0];
			if (hit_ref) begin
				ref_on_reg <= ~data[`OCTDAC_REF_OFF_BIT];
				gain_reg   <= data[`OCTDAC_GAIN_BIT];
			end
			if (hit_chain) chain_reg <= data[`OCTDAC_CHAIN_BIT];
		end
	end

	// =================================================================
	// readback and serial output enable
	// =================================================================
	wire [CODE_WIDTH-1:0] rb_code = (addr < 4'(CH)) ? in_reg[addr[2:0]] : '0;

	// readback armed by its command, lasts through the next frame
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rb_active_reg <= 1'b0;
			pre_reg       <= 1'b0;
			pre_word_reg  <= 24'h000000;
			oe_reg        <= 1'b0;
		end else begin
			pre_reg <= hit_rb;
			if (hit_rb) begin
				pre_word_reg <= {`OCTDAC_RB_FILL, octdac_align(rb_code)};
			end
			if (exec) begin
				rb_active_reg <= hit_rb;
			end
			oe_reg <= chain_reg | rb_active_reg;
		end
	end

	assign link.preload_strobe = pre_reg;
	assign link.preload_word   = pre_word_reg;

	// =================================================================
	// outputs
	// =================================================================
	assign serial_data_out_oe_o = oe_reg;
	assign input_code_o         = in_reg;
	assign output_code_o        = out_reg;
	assign powerdown_mode_o     = pd_reg;
	assign load_mask_o          = mask_reg;
	assign ref_enable_o         = ref_on_reg;
	assign gain_double_o        = gain_reg;
	assign chain_enable_o       = chain_reg;

endmodule

// ==== octdac_core_sva.sv ====
// concurrent checks on the ports of the command core
`timescale 1ns/10ps
`include "octdac_params.svh"

module octdac_core_sva #(
	parameter int CODE_WIDTH = 16
) (
	input wire logic                                     ref_clk_i,
	input wire logic                                     rst_i,
	input wire logic                                     sclk_i,
	input wire logic                                     frame_sel_n_i,
	input wire logic                                     serial_data_in_i,
	input wire logic                                     load_outputs_n_i,
	input wire logic                                     chip_scale_i,
	input wire logic                                     serial_data_out_o,
	input wire logic                                     serial_data_out_oe_o,
	input wire logic [`OCTDAC_CHANNELS-1:0][CODE_WIDTH-1:0] input_code_o,
	input wire logic [`OCTDAC_CHANNELS-1:0][CODE_WIDTH-1:0] output_code_o,
	input wire logic [15:0]                              powerdown_mode_o,
	input wire logic [7:0]                               load_mask_o,
	input wire logic                                     ref_enable_o,
	input wire logic                                     gain_double_o,
	input wire logic                                     chain_enable_o
);
	// =================================================================
	// one clock domain, reset disables every check
	// =================================================================
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// load line falls while select has been idle, no channel masked
	sequence s_load_fall;
		frame_sel_n_i[*4] ##0 ($fell(load_outputs_n_i) && load_mask_o == 8'h00);
	endsequence
	// select stays idle long enough for the copy to land
	sequence s_idle_wait;
		frame_sel_n_i[*5];
	endsequence

	property p_reset_vals;
		$fell(rst_i) |-> input_code_o == '0 && output_code_o == '0
			&& powerdown_mode_o == 16'h0000 && load_mask_o == 8'h00 && ref_enable_o
			&& !gain_double_o && !chain_enable_o && !serial_data_out_oe_o;
	endproperty
	property p_cfg_after_frame;
		$changed({powerdown_mode_o, load_mask_o, ref_enable_o, gain_double_o,
			chain_enable_o}) |-> frame_sel_n_i && (!$past(frame_sel_n_i, 3)
			|| !$past(frame_sel_n_i, 4) || !$past(frame_sel_n_i, 5)
			|| !$past(frame_sel_n_i, 6) || !$past(frame_sel_n_i, 7));
	endproperty
	property p_input_after_frame;
		$changed(input_code_o) |-> frame_sel_n_i && (!$past(frame_sel_n_i, 3)
			|| !$past(frame_sel_n_i, 4) || !$past(frame_sel_n_i, 5)
			|| !$past(frame_sel_n_i, 6) || !$past(frame_sel_n_i, 7));
	endproperty
	property p_in_quiet;
		(!frame_sel_n_i)[*8] |-> $stable(input_code_o);
	endproperty
	property p_out_quiet;
		(frame_sel_n_i && load_outputs_n_i)[*8] |-> $stable(output_code_o);
	endproperty
	property p_load_copy;
		s_load_fall ##1 s_idle_wait |-> output_code_o == input_code_o;
	endproperty
	property p_oe_chain;
		chain_enable_o |=> serial_data_out_oe_o;
	endproperty
	property p_sdo_quiet;
		frame_sel_n_i[*8] ##1 frame_sel_n_i[*2] |-> $stable(serial_data_out_o);
	endproperty

	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	a_cfg_after_frame: assert property (p_cfg_after_frame) else $error("setup moved");
	a_input_after_frame: assert property (p_input_after_frame) else $error("input moved");
	a_in_quiet: assert property (p_in_quiet) else $error("input moved in frame");
	a_out_quiet: assert property (p_out_quiet) else $error("output moved idle");
	a_load_copy: assert property (p_load_copy) else $error("load copy missing");
	a_oe_chain: assert property (p_oe_chain) else $error("oe not driven");
	a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo moved idle");
endmodule

bind octdac_command_core octdac_core_sva #(.CODE_WIDTH(CODE_WIDTH)) octdac_core_sva_i (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .frame_sel_n_i(frame_sel_n_i),
	.serial_data_in_i(serial_data_in_i), .load_outputs_n_i(load_outputs_n_i),
	.chip_scale_i(chip_scale_i), .serial_data_out_o(serial_data_out_o),
	.serial_data_out_oe_o(serial_data_out_oe_o), .input_code_o(input_code_o),
	.output_code_o(output_code_o), .powerdown_mode_o(powerdown_mode_o),
	.load_mask_o(load_mask_o), .ref_enable_o(ref_enable_o),
	.gain_double_o(gain_double_o), .chain_enable_o(chain_enable_o)
);

// ==== octdac_host_model.sv ====
// serial host model that frames words into the converter
`timescale 1ns/10ps

module octdac_host_model (
	input  wire logic   ref_clk_i,
	input  wire logic   sdo_i,
	output logic        sclk_o,
	output logic        frame_sel_n_o,
	output logic        sdi_o,
	output logic [23:0] rx_word_o
);
	// =================================================================
	// idle levels: clock parked high, select high
	// =================================================================
	initial begin
		sclk_o = 1'b1;
		frame_sel_n_o = 1'b1;
		sdi_o = 1'b0;
		rx_word_o = 24'h000000;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// one bit: data set up in high phase, 160 ns clock period
	task automatic put_bit(input logic b);
		sdi_o <= b;
		wait_clk(10);
		sclk_o <= 1'b0;
		rx_word_o <= {rx_word_o[22:0], sdo_i};
		wait_clk(20);
		sclk_o <= 1'b1;
		wait_clk(10);
	endtask

	// close: select high, data line flipped so no stale level lingers
	task automatic close_frame();
		frame_sel_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		wait_clk(16);
	endtask

	task automatic send_frame(input logic [23:0] w);
		frame_sel_n_o <= 1'b0;
		wait_clk(10);
		for (int i = 23; i >= 0; i--) put_bit(w[i]);
		close_frame();
	endtask

	// up to 48 bits: longer frames chain through, shorter ones cut
	task automatic send_bits(input logic [47:0] w, input int n);
		frame_sel_n_o <= 1'b0;
		wait_clk(10);
		for (int i = n - 1; i >= 0; i--) put_bit(w[i]);
		close_frame();
	endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the octal converter command core
`timescale 1ns/10ps

module testbench
	import octdac_pkg::*;
;
	logic             ref_clk_i;
	logic             rst_i;
	logic             load_outputs_n_i;
	logic             chip_scale_i;
	wire logic        sclk;
	wire logic        sel_n;
	wire logic        serial_data_in;
	logic             serial_data_out;
	logic             sdo_oe;
	wire logic        sdo_pin;   // serial output as the host sees it
	logic [7:0][15:0] in_code;
	logic [7:0][15:0] out_code;
	logic [15:0]      pd;
	logic [7:0]       mask;
	logic             ref_en;
	logic             gain;
	logic             chain;
	logic [15:0]      e_in [8];  // expected input registers
	logic [15:0]      e_out [8]; // expected output registers
	logic [15:0]      e_pd;
	logic [7:0]       e_mask;
	logic             e_ref;
	logic             e_gain;
	logic             e_chain;
	logic [3:0]       idle_cmds [5] = '{4'h0, 4'hC, 4'hD, 4'hE, 4'hF};
	int               miscompares;
	int               n_tests;
	int               cycles = 0;

	octdac_command_core #(.CODE_WIDTH(16)) octdac_command_core_i (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk), .frame_sel_n_i(sel_n),
		.serial_data_in_i(serial_data_in), .load_outputs_n_i(load_outputs_n_i),
		.chip_scale_i(chip_scale_i), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(sdo_oe),
		.input_code_o(in_code), .output_code_o(out_code), .powerdown_mode_o(pd),
		.load_mask_o(mask), .ref_enable_o(ref_en), .gain_double_o(gain),
		.chain_enable_o(chain));

	// undriven line reads inverted, so a missing output enable shows up
	assign sdo_pin = sdo_oe ? serial_data_out : ~serial_data_out;

	octdac_host_model octdac_host_model_i (
		.ref_clk_i(ref_clk_i), .sdo_i(sdo_pin), .sclk_o(sclk), .frame_sel_n_o(sel_n),
		.sdi_o(serial_data_in), .rx_word_o());

	// =================================================================
	// clock and run limit
	// =================================================================
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude();
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// compare every register port with the expected image
	task automatic chk_regs();
		for (int i = 0; i < 8; i++) begin
			chk("input_code", e_in[i], in_code[i]);
			chk("output_code", e_out[i], out_code[i]);
		end
		chk("config", {e_pd, e_mask, e_ref, e_gain, e_chain}, {pd, mask, ref_en, gain, chain});
	endtask

	task automatic reset_exp();
		for (int i = 0; i < 8; i++) begin
			e_in[i] = 16'h0000;
			e_out[i] = 16'h0000;
		end
		{e_pd, e_mask, e_ref, e_gain, e_chain} = {16'h0000, 8'h00, 3'b100};
	endtask

	task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
		octdac_host_model_i.send_frame({c, a, d});
	endtask

	task automatic pulse_load();
		load_outputs_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		load_outputs_n_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
	endtask

	// =================================================================
	// main sequence
	// =================================================================
	initial begin
		miscompares = 0;
		n_tests = 0;
		rst_i = 1'b1;
		load_outputs_n_i = 1'b1;
		chip_scale_i = 1'b0;
		reset_exp();
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		chk_regs();
		frame(OCTDAC_CMD_WR_IN, 4'h2, 16'hABCD);
		e_in[2] = 16'hABCD;
		chk_regs();
		pulse_load();
		e_out[2] = 16'hABCD;
		chk_regs();
		frame(OCTDAC_CMD_WR_UPD, 4'h7, 16'h1234);
		e_in[7] = 16'h1234;
		e_out[7] = 16'h1234;
		chk_regs();
		frame(OCTDAC_CMD_WR_IN, 4'h9, 16'h5555);
		chk_regs();
		frame(OCTDAC_CMD_WR_ALL, 4'h0, 16'h0F0F);
		for (int i = 0; i < 8; i++) e_in[i] = 16'h0F0F;
		chk_regs();
		frame(OCTDAC_CMD_UPDATE, 4'h0, 16'h0081);
		e_out[0] = 16'h0F0F;
		e_out[7] = 16'h0F0F;
		chk_regs();
		frame(OCTDAC_CMD_LOAD_MASK, 4'h0, 16'h0004);
		e_mask = 8'h04;
		chk_regs();
		// load held low: falling edge copies unmasked, writes to unmasked channels pass through
		load_outputs_n_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
		for (int i = 0; i < 8; i++) if (i != 2) e_out[i] = e_in[i];
		frame(OCTDAC_CMD_WR_IN, 4'h2, 16'h7777);
		frame(OCTDAC_CMD_WR_IN, 4'h3, 16'h3333);
		load_outputs_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		e_in[2] = 16'h7777;
		e_in[3] = 16'h3333;
		e_out[3] = 16'h3333;
		chk_regs();
		frame(OCTDAC_CMD_POWER, 4'h0, 16'hC001);
		frame(OCTDAC_CMD_REF_GAIN, 4'h0, 16'h0005);
		e_pd = 16'hC001;
		e_ref = 1'b0;
		e_gain = 1'b1;
		chk_regs();
		for (int k = 0; k < 5; k++) frame(idle_cmds[k], 4'h0, 16'hFFFF);
		chk_regs();
		frame(OCTDAC_CMD_WRUPD_ALL, 4'h0, 16'h2468);
		for (int i = 0; i < 8; i++) {e_in[i], e_out[i]} = {16'h2468, 16'h2468};
		chk_regs();
		frame(OCTDAC_CMD_READBACK, 4'h3, 16'h0000);
		frame(OCTDAC_CMD_NOP, 4'h0, 16'h0000);
		chk("readback", 24'h002468, octdac_host_model_i.rx_word_o);
		frame(OCTDAC_CMD_CHAIN, 4'h0, 16'h0001);
		e_chain = 1'b1;
		chk_regs();
		chk("sdo_oe", 1'b1, sdo_oe);
		octdac_host_model_i.send_bits(48'h151234_F00000, 48);
		chk("chain_out", 24'h151234, octdac_host_model_i.rx_word_o);
		chk_regs();
		chip_scale_i <= 1'b1;
		frame(OCTDAC_CMD_WR_IN, 4'h1, 16'h1111);
		e_in[1] = 16'h1111;
		e_out[1] = 16'h1111;
		chk_regs();
		// 12 bits after 0x111111 leave 0x1113AB in the shift register
		octdac_host_model_i.send_bits(48'h0003AB, 12);
		e_in[1] = 16'h13AB;
		e_out[1] = 16'h13AB;
		chk_regs();
		frame(OCTDAC_CMD_SW_RESET, 4'h0, 16'h0000);
		reset_exp();
		chk_regs();
		chk("sdo_oe", 1'b0, sdo_oe);
		conclude();
	end
endmodule
